// ### dsg_clock_gate.sv
// peripheral clock gate controller with run, sleep and deep-sleep gate registers
//
// Design decision made here: register access over Avalon-MM.
module dsg_clock_gate
   import dsg_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire dsg_bus_req_t          bus_req,
   output dsg_bus_rsp_t               bus_rsp,
   input  wire logic                  sleep_req,
   input  wire logic                  deep_sleep_req,
   input  wire dsg_unit_req_t         unit_req,
   output logic                       unit_grant,
   output logic                       unit_fault,
   output logic [DSG_NGATE-1:0]       unit_clk_en,
   output dsg_mode_t                  power_mode,
   output logic                       irq
);
   dsg_bus_rsp_t          rsp_ff;
   logic [31:0]           run_gate_ff;
   logic [31:0]           slp_gate_ff;
   logic [31:0]           dsl_gate_ff;
   logic [31:0]           run_cfg_ff;
   logic [DSG_NEV-1:0]    ev_stat_ff;
   logic [DSG_NEV-1:0]    ev_mask_ff;
   logic [DSG_NGATE-1:0]  clk_en_ff;
   logic                  grant_ff;
   logic                  fault_ff;
   logic                  irq_ff;
   dsg_mode_t             mode_ff;
   dsg_mode_t             nxt_mode;
   logic [31:0]           nxt_gate;
   logic                  req;
   logic                  done;
   logic                  wr_run;
   logic                  wr_slp;
   logic                  wr_dsl;
   logic                  wr_cfg;
   logic                  wr_stat;
   logic                  wr_mask;
   logic [31:0]           bemask;
   logic                  auto_clock_gating_select;
   logic                  ev_fault;
   logic                  ev_mode;

   // merge write data into an old value under byte enables and an implemented-bit mask
   function automatic logic [31:0] dsg_merge(input logic [31:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [31:0] bm,
                                             input logic [31:0] impl);
      dsg_merge = ((old_v & ~bm) | (wd & bm)) & impl;
   endfunction

   function automatic logic dsg_hit(input logic [DSG_AW-1:0] a);
      dsg_hit = (a == DSG_OFF_RUN_CFG)  || (a == DSG_OFF_RUN_GATE) ||
                (a == DSG_OFF_SLP_GATE) || (a == DSG_OFF_DSL_GATE) ||
                (a == DSG_OFF_IRQ_STAT) || (a == DSG_OFF_IRQ_MASK);
   endfunction

   assign req     = bus_req.read || bus_req.write;
   // transfer completes at the edge where waitrequest is sampled low
   assign done    = req && !rsp_ff.waitrequest;
   assign bemask  = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
                     {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};
   assign wr_run  = done && bus_req.write && (bus_req.address == DSG_OFF_RUN_GATE);
   assign wr_slp  = done && bus_req.write && (bus_req.address == DSG_OFF_SLP_GATE);
   assign wr_dsl  = done && bus_req.write && (bus_req.address == DSG_OFF_DSL_GATE);
   assign wr_cfg  = done && bus_req.write && (bus_req.address == DSG_OFF_RUN_CFG);
   assign wr_stat = done && bus_req.write && (bus_req.address == DSG_OFF_IRQ_STAT);
   assign wr_mask = done && bus_req.write && (bus_req.address == DSG_OFF_IRQ_MASK);
   assign auto_clock_gating_select     = run_cfg_ff[DSG_ACG_BIT];

   // one wait state on every access, so read data can come straight from a flop
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rsp_ff.waitrequest <= 1'b1;
         rsp_ff.readdata    <= 32'h00000000;
         rsp_ff.response    <= DSG_RSP_OKAY;
      end else if (req && rsp_ff.waitrequest) begin
         rsp_ff.waitrequest <= 1'b0;
         rsp_ff.response    <= dsg_hit(bus_req.address) ? DSG_RSP_OKAY : DSG_RSP_SLVERR;
         rsp_ff.readdata    <= 32'h00000000;
         if (bus_req.read) begin
            case (bus_req.address)
               DSG_OFF_RUN_CFG:  rsp_ff.readdata <= run_cfg_ff;
               DSG_OFF_RUN_GATE: rsp_ff.readdata <= run_gate_ff;
               DSG_OFF_SLP_GATE: rsp_ff.readdata <= slp_gate_ff;
               DSG_OFF_DSL_GATE: rsp_ff.readdata <= dsl_gate_ff;
               DSG_OFF_IRQ_STAT: rsp_ff.readdata <= {30'h00000000, ev_stat_ff};
               DSG_OFF_IRQ_MASK: rsp_ff.readdata <= {30'h00000000, ev_mask_ff};
               default:          rsp_ff.readdata <= 32'h00000000;
            endcase
         end
      end else begin
         rsp_ff.waitrequest <= 1'b1;
      end
   end

   // three gate registers of identical layout
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         run_gate_ff <= DSG_GATE_RST;
         slp_gate_ff <= DSG_GATE_RST;
         dsl_gate_ff <= DSG_GATE_RST;
      end else begin
         if (wr_run) begin
            run_gate_ff <= dsg_merge(run_gate_ff, bus_req.writedata, bemask, DSG_GATE_IMPL);
         end
         if (wr_slp) begin
            slp_gate_ff <= dsg_merge(slp_gate_ff, bus_req.writedata, bemask, DSG_GATE_IMPL);
         end
         if (wr_dsl) begin
            // the impl mask keeps reserved bits at zero
            dsl_gate_ff <= dsg_merge(dsl_gate_ff, bus_req.writedata, bemask, DSG_GATE_IMPL);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         run_cfg_ff <= DSG_CFG_RST;
      end else if (wr_cfg) begin
         run_cfg_ff <= dsg_merge(run_cfg_ff, bus_req.writedata, bemask, DSG_CFG_IMPL);
      end
   end

   // power mode tracks the core's requests; deep sleep takes priority over sleep
   always_comb begin
      nxt_mode = DSG_MODE_RUN;
      if (deep_sleep_req) begin
         nxt_mode = DSG_MODE_DEEP;
      end else if (sleep_req) begin
         nxt_mode = DSG_MODE_SLEEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mode_ff <= DSG_MODE_RUN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // gate set selected by the current power mode and the auto gating bit (sleep and deep sleep use run gates when it is clear), applied next cycle
   always_comb begin
      nxt_gate = run_gate_ff;
      case (mode_ff)
         DSG_MODE_RUN:   nxt_gate = run_gate_ff;
         DSG_MODE_SLEEP: nxt_gate = auto_clock_gating_select ? slp_gate_ff : run_gate_ff;
         DSG_MODE_DEEP:  nxt_gate = auto_clock_gating_select ? dsl_gate_ff : run_gate_ff;
         default:        nxt_gate = run_gate_ff;
      endcase
   end

   // registered enables drive the unit clock gates, one cycle behind a change
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         clk_en_ff <= DSG_GATE_RST[DSG_NGATE-1:0];
      end else begin
         clk_en_ff <= nxt_gate[DSG_NGATE-1:0];
      end
   end

   // unit access check uses the enables the unit really sees this cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         grant_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         grant_ff <= unit_req.valid && (unit_req.gate_bit < 5'(DSG_NGATE)) &&
                     clk_en_ff[unit_req.gate_bit];
         fault_ff <= unit_req.valid && !((unit_req.gate_bit < 5'(DSG_NGATE)) &&
                     clk_en_ff[unit_req.gate_bit]);
      end
   end

   assign ev_fault = fault_ff;
   assign ev_mode  = (nxt_mode != mode_ff);

   // sticky events, a new event wins over a write-one clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ev_stat_ff <= DSG_EV_RST;
      end else begin
         ev_stat_ff[DSG_EV_FAULT] <= ev_fault ||
            (ev_stat_ff[DSG_EV_FAULT] && !(wr_stat && bus_req.byteenable[0] &&
             bus_req.writedata[DSG_EV_FAULT]));
         ev_stat_ff[DSG_EV_MODE]  <= ev_mode ||
            (ev_stat_ff[DSG_EV_MODE] && !(wr_stat && bus_req.byteenable[0] &&
             bus_req.writedata[DSG_EV_MODE]));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ev_mask_ff <= DSG_EV_RST;
      end else if (wr_mask && bus_req.byteenable[0]) begin
         ev_mask_ff <= bus_req.writedata[DSG_NEV-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(ev_stat_ff & ev_mask_ff);
      end
   end

   assign bus_rsp     = rsp_ff;
   assign unit_grant  = grant_ff;
   assign unit_fault  = fault_ff;
   assign unit_clk_en = clk_en_ff;
   assign power_mode  = mode_ff;
   assign irq         = irq_ff;

   a_gate_applied: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode_ff == DSG_MODE_RUN) ##1 (mode_ff == DSG_MODE_RUN)
      |-> clk_en_ff == $past(run_gate_ff[DSG_NGATE-1:0]))
      else $error("unit clock enables do not follow the run gate register");

   a_gated_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
      (unit_req.valid && (unit_req.gate_bit < 5'(DSG_NGATE)) && !clk_en_ff[unit_req.gate_bit])
      |=> (fault_ff && !grant_ff) ##1 ev_stat_ff[DSG_EV_FAULT])
      else $error("access to a gated unit did not fault");

   // looks one edge past each reset cycle, so no history before the first edge is needed
   a_reset_gated: assert property (@(posedge clk_sys)
      !resetn |=> (dsl_gate_ff == 32'h00000000) && (clk_en_ff == 20'h00000))
      else $error("deep sleep gate not cleared by reset");

   a_regs_separate: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_slp |=> $stable(dsl_gate_ff) && $stable(run_gate_ff))
      else $error("sleep gate write disturbed another gate register");

   a_sleep_acg: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode_ff == DSG_MODE_SLEEP && auto_clock_gating_select) |=> clk_en_ff == $past(slp_gate_ff[DSG_NGATE-1:0]))
      else $error("sleep gate not applied with automatic gating");

   a_timer_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_dsl && bus_req.byteenable[2]) |=> dsl_gate_ff[19:16] == $past(bus_req.writedata[19:16]))
      else $error("timer enables not stored at bits 19 to 16");

   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
      ((dsl_gate_ff & ~DSG_GATE_IMPL) == 32'h00000000) &&
      (!(done && bus_req.read && bus_req.address == DSG_OFF_DSL_GATE) ||
       rsp_ff.readdata[31:20] == 12'h000))
      else $error("reserved deep sleep gate bit not zero");

   a_two_wire_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_dsl && bus_req.byteenable[1]) |=> dsl_gate_ff[15:12] ==
      ($past(bus_req.writedata[15:12]) & 4'h5))
      else $error("two-wire enables misplaced");

   a_serial_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_dsl && bus_req.byteenable[0]) |=> dsl_gate_ff[11:4] ==
      {6'h00, $past(bus_req.writedata[5:4])})
      else $error("sync serial enables misplaced");

   a_async_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_dsl && bus_req.byteenable[0]) |=> dsl_gate_ff[3:0] ==
      {1'b0, $past(bus_req.writedata[2:0])})
      else $error("async serial enables misplaced");

   a_deep_no_acg: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode_ff == DSG_MODE_DEEP && !auto_clock_gating_select) |=> clk_en_ff == $past(run_gate_ff[DSG_NGATE-1:0]))
      else $error("deep sleep without automatic gating left run settings");

   a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
      irq_ff == $past(|(ev_stat_ff & ev_mask_ff)))
      else $error("interrupt does not reflect masked status");
endmodule

// ### dsg_pkg.sv
// constants and carrier types for the deep-sleep peripheral clock gate controller
package dsg_pkg;
   localparam int          DSG_AW            = 10;
   localparam int          DSG_DW            = 32;
   localparam int          DSG_NGATE         = 20;
   // register byte offsets
   localparam logic [9:0]  DSG_OFF_RUN_CFG   = 10'h060;
   localparam logic [9:0]  DSG_OFF_RUN_GATE  = 10'h100;
   localparam logic [9:0]  DSG_OFF_SLP_GATE  = 10'h110;
   localparam logic [9:0]  DSG_OFF_DSL_GATE  = 10'h124;
   localparam logic [9:0]  DSG_OFF_IRQ_STAT  = 10'h130;
   localparam logic [9:0]  DSG_OFF_IRQ_MASK  = 10'h134;
   // field positions and event count
   localparam int          DSG_ACG_BIT       = 0;
   localparam int          DSG_EV_FAULT      = 0;
   localparam int          DSG_EV_MODE       = 1;
   localparam int          DSG_NEV           = 2;
   localparam int          DSG_TMR0_BIT      = 16;
   localparam int          DSG_TW0_BIT       = 12;
   localparam int          DSG_TW1_BIT       = 14;
   localparam int          DSG_SYNC_SERIAL_0_CLOCK_ENABLE_BIT      = 4;
   localparam int          DSG_ASYNC_SERIAL_0_CLOCK_ENABLE_BIT     = 0;
   // implemented gate and config bits; all others read as zero
   localparam logic [31:0] DSG_GATE_IMPL     = 32'h000F5037;
   localparam logic [31:0] DSG_CFG_IMPL      = 32'h00000001;
   // reset values and bus response codes
   localparam logic [31:0] DSG_GATE_RST      = 32'h00000000;
   localparam logic [31:0] DSG_CFG_RST       = 32'h00000000;
   localparam logic [1:0]  DSG_EV_RST        = 2'h0;
   localparam logic [1:0]  DSG_RSP_OKAY      = 2'h0;
   localparam logic [1:0]  DSG_RSP_SLVERR    = 2'h2;

   typedef enum logic [2:0] {
      DSG_MODE_RUN   = 3'h1,
      DSG_MODE_SLEEP = 3'h2,
      DSG_MODE_DEEP  = 3'h4
   } dsg_mode_t;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [DSG_AW-1:0] address;
      logic [DSG_DW-1:0] writedata;
      logic [3:0]        byteenable;
   } dsg_bus_req_t;

   typedef struct packed {
      logic [DSG_DW-1:0] readdata;
      logic              waitrequest;
      logic [1:0]        response;
   } dsg_bus_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] gate_bit;
   } dsg_unit_req_t;
endpackage

// ### tb_top.sv
// self-checking testbench for the deep-sleep peripheral clock gate controller
module tb_top
   import dsg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] exp_impl = 32'h000F5037;
   localparam logic [31:0] run_pat  = 32'h00054015;
   localparam logic [31:0] slp_pat  = 32'h000A1022;
   localparam logic [31:0] dsl_pat  = 32'h000F0007;

   logic                 clk_sys        = 1'b0;
   logic                 resetn         = 1'b0;
   dsg_bus_req_t         bus_req        = '0;
   dsg_bus_rsp_t         bus_rsp;
   logic                 sleep_req      = 1'b0;
   logic                 deep_sleep_req = 1'b0;
   dsg_unit_req_t        unit_req       = '0;
   logic                 unit_grant;
   logic                 unit_fault;
   logic [DSG_NGATE-1:0] unit_clk_en;
   dsg_mode_t            power_mode;
   logic                 irq;
   int                   errors         = 0;
   int                   n_compared     = 0;
   logic [9:0]           offs [6];

   always #2 clk_sys = ~clk_sys;

   dsg_clock_gate i_dsg_clock_gate (
      .clk_sys        (clk_sys),
      .resetn         (resetn),
      .bus_req        (bus_req),
      .bus_rsp        (bus_rsp),
      .sleep_req      (sleep_req),
      .deep_sleep_req (deep_sleep_req),
      .unit_req       (unit_req),
      .unit_grant     (unit_grant),
      .unit_fault     (unit_fault),
      .unit_clk_en    (unit_clk_en),
      .power_mode     (power_mode),
      .irq            (irq)
   );

   task automatic summarize;
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one access; the request stays put until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                      input logic [3:0] be, output logic [31:0] rdata, output logic [1:0] resp);
      int n;
      @(posedge clk_sys);
      bus_req.read       <= !wr;
      bus_req.write      <= wr;
      bus_req.address    <= addr;
      bus_req.writedata  <= wdata;
      bus_req.byteenable <= be;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("mismatch waitrequest expected 0 seen %b", bus_rsp.waitrequest);
      end
      rdata = bus_rsp.readdata;
      resp  = bus_rsp.response;
      bus_req.read  <= 1'b0;
      bus_req.write <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] addr, input logic [31:0] data,
                     input logic [1:0] exp_resp = DSG_RSP_OKAY, input logic [3:0] be = 4'hF);
      logic [31:0] d;
      logic [1:0]  r;
      bus(1'b1, addr, data, be, d, r);
      chk("write response", 32'(exp_resp), 32'(r));
   endtask

   task automatic rd(input logic [9:0] addr, input logic [31:0] exp,
                     input logic [1:0] exp_resp = DSG_RSP_OKAY);
      logic [31:0] d;
      logic [1:0]  r;
      bus(1'b0, addr, 32'h0, 4'hF, d, r);
      chk("read data", exp, d);
      chk("read response", 32'(exp_resp), 32'(r));
   endtask

   // grant or fault is looked at in the one cycle it stands
   task automatic access(input int b, input logic ok);
      @(posedge clk_sys);
      unit_req.valid    <= 1'b1;
      unit_req.gate_bit <= 5'(b);
      @(posedge clk_sys);
      unit_req.valid <= 1'b0;
      @(posedge clk_sys);
      chk("unit grant", 32'(ok), 32'(unit_grant));
      chk("unit fault", 32'(!ok), 32'(unit_fault));
   endtask

   // mode request, then one cycle for the mode and one for the gate outputs
   task automatic mode(input logic s, input logic d);
      @(posedge clk_sys);
      sleep_req      <= s;
      deep_sleep_req <= d;
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      summarize();
   end

   initial begin
      offs = '{DSG_OFF_RUN_CFG, DSG_OFF_RUN_GATE, DSG_OFF_SLP_GATE,
               DSG_OFF_DSL_GATE, DSG_OFF_IRQ_STAT, DSG_OFF_IRQ_MASK};
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk("clock enables", 32'h0, 32'(unit_clk_en));
      chk("power mode", 32'h1, 32'(power_mode));
      foreach (offs[i]) rd(offs[i], 32'h0);
      for (int i = 1; i < 4; i++) begin
         wr(offs[i], 32'hFFFFFFFF);
         rd(offs[i], exp_impl);
      end
      // walking one shows each field position and every reserved bit
      for (int i = 0; i < 32; i++) begin
         wr(DSG_OFF_DSL_GATE, 32'h1 << i);
         rd(DSG_OFF_DSL_GATE, (32'h1 << i) & exp_impl);
      end
      // single byte lanes: only the enabled lane changes, the rest keep their old value
      wr(DSG_OFF_DSL_GATE, 32'hFFFFFFFF, DSG_RSP_OKAY, 4'h4);
      rd(DSG_OFF_DSL_GATE, 32'h000F0000);
      wr(DSG_OFF_DSL_GATE, 32'hFFFFFFFF, DSG_RSP_OKAY, 4'h2);
      rd(DSG_OFF_DSL_GATE, 32'h000F5000);
      wr(DSG_OFF_RUN_GATE, run_pat);
      wr(DSG_OFF_SLP_GATE, slp_pat);
      wr(DSG_OFF_DSL_GATE, dsl_pat);
      repeat (2) @(posedge clk_sys);
      chk("run clock enables", run_pat, 32'(unit_clk_en));
      for (int b = 0; b < 20; b++) access(b, run_pat[b]);
      mode(1'b0, 1'b1);
      chk("power mode", 32'h4, 32'(power_mode));
      chk("deep without auto", run_pat, 32'(unit_clk_en));
      wr(DSG_OFF_RUN_CFG, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("deep with auto", dsl_pat, 32'(unit_clk_en));
      for (int b = 0; b < 20; b++) access(b, dsl_pat[b]);
      mode(1'b1, 1'b0);
      chk("power mode", 32'h2, 32'(power_mode));
      chk("sleep with auto", slp_pat, 32'(unit_clk_en));
      mode(1'b1, 1'b1);
      chk("deep over sleep", dsl_pat, 32'(unit_clk_en));
      mode(1'b0, 1'b0);
      chk("run with auto", run_pat, 32'(unit_clk_en));
      // faults and mode changes above left both events pending, masked
      chk("irq masked", 32'h0, 32'(irq));
      rd(DSG_OFF_IRQ_STAT, 32'h3);
      wr(DSG_OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq fault", 32'h1, 32'(irq));
      wr(DSG_OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq cleared", 32'h0, 32'(irq));
      rd(DSG_OFF_IRQ_STAT, 32'h2);
      wr(DSG_OFF_IRQ_STAT, 32'h2);
      rd(DSG_OFF_IRQ_STAT, 32'h0);
      access(3, 1'b0);
      repeat (3) @(posedge clk_sys);
      chk("irq new fault", 32'h1, 32'(irq));
      wr(DSG_OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("irq mask off", 32'h0, 32'(irq));
      wr(10'h200, 32'hFFFFFFFF, DSG_RSP_SLVERR);
      rd(10'h200, 32'h0, DSG_RSP_SLVERR);
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk("clock enables", 32'h0, 32'(unit_clk_en));
      rd(DSG_OFF_DSL_GATE, 32'h0);
      access(0, 1'b0);
      summarize();
   end
endmodule
